// *** logic/upc_map.vh ***
`ifndef UPC_MAP_VH
`define UPC_MAP_VH

// Register byte offsets
`define UPC_OFS_PID 8'h2c
`define UPC_OFS_EP 8'h30
`define UPC_OFS_TAG 8'h34
`define UPC_OFS_OTG 8'h38
`define UPC_OFS_PWR 8'h3c
`define UPC_OFS_PHY 8'h40
`define UPC_OFS_IRQ_STAT 8'h44
`define UPC_OFS_IRQ_MASK 8'h48

// Field positions
`define UPC_PID_MSB 3
`define UPC_EP_MSB 3
`define UPC_EP_VALID_BIT 4
`define UPC_TAG_MSB 15
`define UPC_TAG_OR 5'h10
`define UPC_PWR_MSB 8
`define UPC_PHY_PD_DIS_BIT 18
`define UPC_PHY_SE0_BIT 13
`define UPC_PHY_K_BIT 12
`define UPC_PHY_LOG_MSB 11
`define UPC_PHY_LOG_LSB 8
`define UPC_PHY_SREN_BIT 7
`define UPC_PHY_CONF_MSB 6
`define UPC_PHY_CONF_LSB 4
`define UPC_PHY_RW_MASK 32'h0004_3ff0

// Interrupt status bits
`define UPC_IRQ_TOKEN_BIT 0
`define UPC_IRQ_SE0_BIT 1
`define UPC_IRQ_K_BIT 2
`define UPC_IRQ_W 3

// Line states
`define UPC_LS_SE0 2'h0
`define UPC_LS_K 2'h2

// Reset values and bus answers
`define UPC_RST_ZERO 32'h0000_0000
`define UPC_RESP_OKAY 2'h0
`define UPC_RESP_SLVERR 2'h2

`endif

// *** logic/upc_regs.v ***
// How it works
// - Each decoded packet's 4-bit PID is held read-only; zero after reset.
// - Last received endpoint number is held read-only, four bits; zero after reset.
// - Flag beside endpoint reads one only when the captured endpoint is valid.
// - 16-bit mask per endpoint; masked endpoints leave on receive port ORed with 0x10.
// - Writable bit, reset zero; one disables pulldowns on the two 8-bit ports.
// - After auto-resume by SE0 a flag sets; it stays until software writes zero.
// - After auto-resume by K a separate flag sets; cleared by writing zero.
// - Line-state change propagates only after two-to-the-field-value stable cycles.
// - Enable bit lets suspend controller resume; otherwise software polls filtered state.
// - PHY's three configuration pins driven straight from a writable field.
`timescale 1ns/1ps
`include "upc_map.vh"

module upc_regs #(
  parameter FILT_W = 16
) (
  input wire mclk,
  input wire rst,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Token decoder, same clock
  input wire tok_done,
  input wire [3:0] tok_pid,
  input wire [3:0] tok_ep,
  input wire tok_ep_valid,
  // PHY line state pins and suspend state
  input wire [1:0] linestate,
  input wire suspended,
  // Receive port
  output reg [4:0] rx_ep_tagged,
  output reg rx_ep_strobe,
  // Module side outputs
  output reg [1:0] linestate_filt,
  output reg resume_wake,
  output reg pulldown_disable,
  output reg [2:0] transceiver_config_pins,
  output reg [31:0] otg_flag_mask,
  output reg [8:0] power_signal_word,
  output reg irq
);

  reg [3:0] last_packet_id;
  reg [3:0] last_endpoint;
  reg endpoint_valid;
  reg [15:0] endpoint_tag_mask;
  reg [31:0] transceiver_control;
  reg [`UPC_IRQ_W-1:0] irq_status;
  reg [`UPC_IRQ_W-1:0] irq_mask;

  reg [7:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;

  reg [1:0] ls_s1;
  reg [1:0] ls_s2;
  reg [1:0] ls_s3;
  reg [1:0] ls_stable;
  reg [1:0] ls_cand;
  reg [FILT_W-1:0] filt_cnt;

  reg [31:0] rd_word;
  reg rd_hit;
  reg [31:0] next_phy;
  reg [`UPC_IRQ_W-1:0] irq_set;
  reg se0_wake;
  reg k_wake;
  reg filt_step;

  wire wr_fire;
  wire rd_fire;
  wire [FILT_W-1:0] filt_target;

  function [31:0] upc_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      upc_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          upc_merge[8*i +: 8] = data[8*i +: 8];
        end
      end
    end
  endfunction

  function upc_wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      upc_wr_hit = (addr == ofs);
    end
  endfunction

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  wire [31:0] tag_merged = upc_merge({16'h0000, endpoint_tag_mask}, w_data, w_strb);
  wire [31:0] pwr_merged = upc_merge({23'h00_0000, power_signal_word}, w_data, w_strb);
  // A change counts only once it has held stable for this many cycles
  assign filt_target = {{(FILT_W-1){1'b0}}, 1'b1} <<
    transceiver_control[`UPC_PHY_LOG_MSB:`UPC_PHY_LOG_LSB];

  // Read mux
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `UPC_OFS_PID: rd_word = {28'h000_0000, last_packet_id};
      `UPC_OFS_EP: rd_word = {27'h000_0000, endpoint_valid, last_endpoint};
      `UPC_OFS_TAG: rd_word = {16'h0000, endpoint_tag_mask};
      `UPC_OFS_OTG: rd_word = otg_flag_mask;
      `UPC_OFS_PWR: rd_word = {23'h00_0000, power_signal_word};
      `UPC_OFS_PHY: rd_word = transceiver_control;
      `UPC_OFS_IRQ_STAT: rd_word = {29'h0000_0000, irq_status};
      `UPC_OFS_IRQ_MASK: rd_word = {29'h0000_0000, irq_mask};
      default: begin
        rd_word = `UPC_RST_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Auto-resume events come off the filtered state while suspended
  always @* begin
    filt_step = (ls_stable != linestate_filt) && (ls_stable == ls_cand) &&
      (filt_cnt + {{(FILT_W-1){1'b0}}, 1'b1} >= filt_target);
    se0_wake = filt_step && suspended && transceiver_control[`UPC_PHY_SREN_BIT] &&
      (ls_cand == `UPC_LS_SE0);
    k_wake = filt_step && suspended && transceiver_control[`UPC_PHY_SREN_BIT] &&
      (ls_cand == `UPC_LS_K);
    irq_set = {`UPC_IRQ_W{1'b0}};
    irq_set[`UPC_IRQ_TOKEN_BIT] = tok_done;
    irq_set[`UPC_IRQ_SE0_BIT] = se0_wake;
    irq_set[`UPC_IRQ_K_BIT] = k_wake;
    next_phy = transceiver_control;
    if (wr_fire && upc_wr_hit(aw_addr, `UPC_OFS_PHY)) begin
      next_phy = upc_merge(transceiver_control, w_data, w_strb) & `UPC_PHY_RW_MASK;
    end
    // Hardware set beats a software clear in the same cycle
    if (se0_wake) begin
      next_phy[`UPC_PHY_SE0_BIT] = 1'b1;
    end
    if (k_wake) begin
      next_phy[`UPC_PHY_K_BIT] = 1'b1;
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UPC_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `UPC_RST_ZERO;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `UPC_OFS_PID, `UPC_OFS_EP, `UPC_OFS_TAG, `UPC_OFS_OTG, `UPC_OFS_PWR,
          `UPC_OFS_PHY, `UPC_OFS_IRQ_STAT, `UPC_OFS_IRQ_MASK: begin
            s_axi_bresp <= `UPC_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `UPC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `UPC_RST_ZERO;
      s_axi_rresp <= `UPC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `UPC_RESP_OKAY : `UPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software registers
  always @(posedge mclk) begin
    if (rst) begin
      endpoint_tag_mask <= 16'h0000;
      otg_flag_mask <= `UPC_RST_ZERO;
      power_signal_word <= 9'h000;
      transceiver_control <= `UPC_RST_ZERO;
      irq_mask <= {`UPC_IRQ_W{1'b0}};
    end else begin
      transceiver_control <= next_phy;
      if (wr_fire) begin
        if (upc_wr_hit(aw_addr, `UPC_OFS_TAG)) begin
          endpoint_tag_mask <= tag_merged[`UPC_TAG_MSB:0];
        end
        if (upc_wr_hit(aw_addr, `UPC_OFS_OTG)) begin
          otg_flag_mask <= upc_merge(otg_flag_mask, w_data, w_strb);
        end
        if (upc_wr_hit(aw_addr, `UPC_OFS_PWR)) begin
          power_signal_word <= pwr_merged[`UPC_PWR_MSB:0];
        end
        if (upc_wr_hit(aw_addr, `UPC_OFS_IRQ_MASK)) begin
          irq_mask <= w_strb[0] ? w_data[`UPC_IRQ_W-1:0] : irq_mask;
        end
      end
    end
  end

  // Pin-facing copies of control fields
  always @(posedge mclk) begin
    if (rst) begin
      pulldown_disable <= 1'b0;
      transceiver_config_pins <= 3'h0;
    end else begin
      pulldown_disable <= next_phy[`UPC_PHY_PD_DIS_BIT];
      transceiver_config_pins <= next_phy[`UPC_PHY_CONF_MSB:`UPC_PHY_CONF_LSB];
    end
  end

  // Token capture and receive-port tagging
  always @(posedge mclk) begin
    if (rst) begin
      last_packet_id <= 4'h0;
      last_endpoint <= 4'h0;
      endpoint_valid <= 1'b0;
      rx_ep_tagged <= 5'h00;
      rx_ep_strobe <= 1'b0;
    end else begin
      rx_ep_strobe <= tok_done;
      if (tok_done) begin
        last_packet_id <= tok_pid;
        last_endpoint <= tok_ep;
        endpoint_valid <= tok_ep_valid;
        rx_ep_tagged <= {1'b0, tok_ep} |
          (endpoint_tag_mask[tok_ep] ? `UPC_TAG_OR : 5'h00);
      end
    end
  end

  // Line state: three-stage synchroniser, then the programmable filter
  always @(posedge mclk) begin
    if (rst) begin
      ls_s1 <= 2'h0;
      ls_s2 <= 2'h0;
      ls_s3 <= 2'h0;
      ls_stable <= 2'h0;
      ls_cand <= 2'h0;
      filt_cnt <= {FILT_W{1'b0}};
      linestate_filt <= 2'h0;
      resume_wake <= 1'b0;
    end else begin
      ls_s1 <= linestate;
      ls_s2 <= ls_s1;
      ls_s3 <= ls_s2;
      if (ls_s2 == ls_s3) begin
        ls_stable <= ls_s3;
      end
      resume_wake <= se0_wake || k_wake;
      if (ls_stable == linestate_filt) begin
        filt_cnt <= {FILT_W{1'b0}};
        ls_cand <= ls_stable;
      end else if (ls_stable != ls_cand) begin
        // A bounce restarts the wait so glitches never reach software
        filt_cnt <= {FILT_W{1'b0}};
        ls_cand <= ls_stable;
      end else if (filt_step) begin
        linestate_filt <= ls_cand;
        filt_cnt <= {FILT_W{1'b0}};
      end else begin
        filt_cnt <= filt_cnt + {{(FILT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Interrupts: sticky status, cleared by a read, set wins
  always @(posedge mclk) begin
    if (rst) begin
      irq_status <= {`UPC_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (rd_fire && s_axi_araddr == `UPC_OFS_IRQ_STAT) begin
        irq_status <= irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule // upc_regs

// *** verification/upc_regs_chk.sv ***
`timescale 1ns/1ps
module upc_regs_chk (
  input wire mclk,
  input wire rst,
  input wire tok_done,
  input wire [3:0] tok_ep,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire [4:0] rx_ep_tagged,
  input wire rx_ep_strobe,
  input wire resume_wake,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_strb; tok_done |=> rx_ep_strobe; endproperty
  a_strb: assert property (p_strb) else $error("no strobe after token");
  property p_idle; !tok_done |=> !rx_ep_strobe; endproperty
  a_idle: assert property (p_idle) else $error("strobe without token");
  property p_ep; tok_done |=> rx_ep_tagged[3:0] == $past(tok_ep); endproperty
  a_ep: assert property (p_ep) else $error("endpoint on receive port wrong");
  property p_wake; resume_wake |=> !resume_wake; endproperty
  a_wake: assert property (p_wake) else $error("wake pulse too long");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rref: assert property (p_rref) else $error("read address taken while busy");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  // Own disable so the reset value itself is watched
  property p_rst; disable iff (1'b0) rst |=> !irq && !rx_ep_strobe && !s_axi_rvalid; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  c_tag: cover property (tok_done ##1 rx_ep_tagged[4]);
  c_wake: cover property (resume_wake);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // upc_regs_chk

bind upc_regs upc_regs_chk i_upc_regs_chk (.mclk, .rst, .tok_done, .tok_ep, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .rx_ep_tagged,
  .rx_ep_strobe, .resume_wake, .irq);

// *** verification/upc_phy_model.sv ***
`timescale 1ns/1ps
module upc_phy_model (
  input wire mclk,
  output reg tok_done,
  output reg [3:0] tok_pid,
  output reg [3:0] tok_ep,
  output reg tok_ep_valid,
  output reg [1:0] linestate
);
  initial begin
    tok_done = 1'b0;
    tok_pid = 4'h0;
    tok_ep = 4'h0;
    tok_ep_valid = 1'b0;
    linestate = 2'h1;
  end
  // Fields are scrambled after the pulse so a design reading them late is caught
  task send(input [3:0] p, input [3:0] e, input v);
    begin
      @(posedge mclk);
      tok_done <= 1'b1;
      tok_pid <= p;
      tok_ep <= e;
      tok_ep_valid <= v;
      @(posedge mclk);
      tok_done <= 1'b0;
      tok_pid <= ~p;
      tok_ep <= ~e;
      tok_ep_valid <= ~v;
    end
  endtask
  task set_ls(input [1:0] s);
    begin
      @(posedge mclk);
      linestate <= s;
    end
  endtask
endmodule // upc_phy_model

// *** verification/upc_regs_tb.sv ***
`timescale 1ns/1ps
module upc_regs_tb;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg suspended = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_ep_strobe;
  wire resume_wake, pulldown_disable, irq, tok_done, tok_ep_valid;
  wire [1:0] s_axi_bresp, s_axi_rresp, linestate, linestate_filt;
  wire [31:0] s_axi_rdata, otg_flag_mask;
  wire [3:0] tok_pid, tok_ep;
  wire [4:0] rx_ep_tagged;
  wire [2:0] transceiver_config_pins;
  wire [8:0] power_signal_word;
  reg [31:0] m [0:31];
  reg [31:0] seed = 32'h7ed4_43f1;
  int error_cnt = 0, total_checks = 0, wk = 0, i;
  upc_regs i_upc_regs (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tok_done, .tok_pid, .tok_ep, .tok_ep_valid, .linestate, .suspended,
    .rx_ep_tagged, .rx_ep_strobe, .linestate_filt, .resume_wake, .pulldown_disable,
    .transceiver_config_pins, .otg_flag_mask, .power_signal_word, .irq);
  upc_phy_model i_upc_phy_model (.mclk, .tok_done, .tok_pid, .tok_ep, .tok_ep_valid, .linestate);
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (resume_wake) wk <= wk + 1;
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      total_checks++;
      if (g !== e) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    int n;
    bit dn;
    reg [1:0] r;
    reg [31:0] rw;
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      dn = 0;
      // Response ready comes late on purpose, so the slave must hold its answer
      for (n = 0; n < 40 && !dn; n++) begin
        @(posedge mclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bready && s_axi_bvalid) begin
          dn = 1;
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end else if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      if (!dn) begin
        error_cnt++;
        final_report;
      end
      if (a >= 8'h2c && a <= 8'h48 && a[1:0] == 2'h0) begin
        chk("bresp", 0, r);
        rw = a == 8'h34 ? 32'h0000_ffff : a == 8'h38 ? 32'hffff_ffff : a == 8'h3c ? 32'h0000_01ff :
          a == 8'h40 ? 32'h0004_3ff0 : a == 8'h48 ? 32'h0000_0007 : 32'h0000_0000;
        // Only strobed byte lanes of writable bits change
        rw = rw & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
          {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        m[a[6:2]] = (m[a[6:2]] & ~rw) | (d & rw);
      end else chk("bresp", 2, r);
    end
  endtask
  task rd(input [7:0] a);
    int n;
    bit dn;
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      dn = 0;
      for (n = 0; n < 40 && !dn; n++) begin
        @(posedge mclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          dn = 1;
          s_axi_rready <= 1'b0;
          chk("rdata", m[a[6:2]], s_axi_rdata);
          chk("rresp", (a >= 8'h2c && a <= 8'h48 && a[1:0] == 2'h0) ? 0 : 2, s_axi_rresp);
        end
      end
      if (!dn) begin
        error_cnt++;
        final_report;
      end
      if (a == 8'h44) m[17] = 0;
    end
  endtask
  initial begin
    foreach (m[k]) m[k] = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    for (i = 11; i <= 18; i++) rd(8'(i * 4));
    seed = lfsr(seed);
    wr(8'h34, seed);
    rd(8'h34);
    seed = lfsr(seed);
    wr(8'h38, seed);
    rd(8'h38);
    chk("otg", m[14], otg_flag_mask);
    s_axi_wstrb <= 4'h5;
    seed = lfsr(seed);
    wr(8'h38, seed);
    s_axi_wstrb <= 4'hf;
    rd(8'h38);
    chk("otg", m[14], otg_flag_mask);
    wr(8'h3c, seed);
    rd(8'h3c);
    chk("pwr", m[15], {23'h0, power_signal_word});
    wr(8'h2c, 32'hffff_ffff);
    rd(8'h2c);
    wr(8'h80, 32'h0000_0001);
    rd(8'h80);
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      i_upc_phy_model.send(seed[3:0], seed[7:4], seed[8]);
      #1 chk("strobe", 1, rx_ep_strobe);
      chk("tag", {m[13][seed[7:4]], seed[7:4]}, rx_ep_tagged);
      m[11] = seed[3:0];
      m[12] = {seed[8], seed[7:4]};
      m[17][0] = 1'b1;
      rd(8'h2c);
      rd(8'h30);
    end
    chk("irq", 0, irq);
    wr(8'h48, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk("irq", 1, irq);
    rd(8'h44);
    repeat (2) @(posedge mclk);
    chk("irq", 0, irq);
    wr(8'h40, 32'h0004_02d0);
    chk("pulldown", 1, pulldown_disable);
    chk("conf", 5, transceiver_config_pins);
    suspended <= 1'b1;
    for (i = 0; i < 2; i++) begin
      i_upc_phy_model.set_ls(i ? 2'h2 : 2'h0);
      repeat (4) @(posedge mclk);
      chk("filt", i ? 0 : 1, linestate_filt);
      repeat (20) @(posedge mclk);
      chk("filt", i ? 2 : 0, linestate_filt);
      m[16] = m[16] | (i ? 32'h0000_1000 : 32'h0000_2000);
      m[17] = m[17] | (i ? 32'h4 : 32'h2);
    end
    chk("wake", 2, wk);
    rd(8'h40);
    wr(8'h48, 32'h0000_0007);
    repeat (2) @(posedge mclk);
    chk("irq", 1, irq);
    rd(8'h44);
    wr(8'h40, 32'h0004_02d0);
    rd(8'h40);
    wr(8'h40, 32'h0000_0200);
    i_upc_phy_model.set_ls(2'h0);
    repeat (30) @(posedge mclk);
    chk("filt", 0, linestate_filt);
    chk("wake", 2, wk);
    rd(8'h40);
    chk("pulldown", 0, pulldown_disable);
    chk("conf", 0, transceiver_config_pins);
    final_report;
  end
endmodule // upc_regs_tb
